// [bench/mcsfc_asserts.sv]
`timescale 1ns/1ps
module mcsfc_asserts (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  // strobes and data
  input wire logic       wr_thr,
  input wire logic       wr_cmd,
  input wire logic       rd_rhr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rhr,
  input wire logic [7:0] status,
  input wire logic       cts_n,
  // bit clocks and flags
  input wire logic       tx_bit_clock,
  input wire logic       rx_bit_clock,
  input wire logic       tx_idle_flag,
  input wire logic       tx_hold_free_flag,
  input wire logic       rx_hold_full_flag,
  input wire logic       first_char_flag
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // shadow of the command byte so the enables are known here
  logic [7:0] cmd_reg;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) cmd_reg <= 8'h25;
    else if (wr_cmd) cmd_reg <= wdata;
  end
  AST_THR_DROPS: assert property (wr_thr |=> !tx_idle_flag && !tx_hold_free_flag)
    else $error("flags stayed after holding write");
  AST_IDLE_FREE: assert property (tx_idle_flag |-> tx_hold_free_flag)
    else $error("idle without free");
  AST_TX_OFF: assert property (!cmd_reg[0] |-> !tx_idle_flag && !tx_hold_free_flag)
    else $error("tx flags while disabled");
  AST_STATUS: assert property (status[2:0] == {tx_idle_flag, rx_hold_full_flag, tx_hold_free_flag}
    && status[6] == first_char_flag && !status[7]) else $error("status differs from flags");
  AST_FIRST_FULL: assert property ($rose(first_char_flag) |-> rx_hold_full_flag)
    else $error("first flag without full");
  AST_READ_CLR: assert property (rd_rhr |=> !rx_hold_full_flag || $changed(rhr))
    else $error("read left full set");
  AST_OVERRUN: assert property ($changed(rhr) && $past(rx_hold_full_flag) && !$past(rd_rhr) |-> status[3])
    else $error("overwrite without overrun");
  // the enable lands one edge after the strobe, and the flags drop one edge later
  AST_RX_OFF: assert property (wr_cmd && !wdata[2] |-> ##2 (!rx_hold_full_flag && !first_char_flag))
    else $error("rx flags after disable");
  // start needs a bit clock edge plus the sync delay, well under 24
  AST_START: assert property (wr_thr && tx_idle_flag && !cts_n && !cmd_reg[3] |-> ##[1:24] tx_hold_free_flag)
    else $error("free flag late after start");
  AST_CLKS: assert property (tx_bit_clock == rx_bit_clock)
    else $error("bit clocks differ");
endmodule // mcsfc_asserts

// [bench/multichar_serial_flow_control_tb.sv]
`timescale 1ns/1ps
`include "mcsfc_consts.svh"
module multichar_serial_flow_control_tb;
  // each row: mode, char count, chars low first
  localparam logic [47:0] rows [4] = '{48'h0001_0000_0013, 48'h1C02_0000_C35A,
                                       48'h2403_002A_1533, 48'hB804_7F01_4055};
  logic        clk;
  logic        rst_n;
  logic        rd;
  logic        wr;
  logic        cut;
  logic        txd;
  logic        txd_low;
  logic        waitreq;
  logic [4:0]  addr;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic [31:0] q;
  int          n_mismatch;
  int          total_checks;

  mcsfc_if mcsfc_if_i ();
  mcsfc_device mcsfc_device_i (.ref_clk_i(clk), .rst_n_i(rst_n), .bus(mcsfc_if_i),
    .rxd_i(cut ? 1'b0 : txd), .txd_o(txd));
  mcsfc_host #(.DIV(4)) mcsfc_host_i (.ref_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .bus(mcsfc_if_i));
  mcsfc_asserts mcsfc_asserts_i (.ref_clk_i(clk), .rst_n_i(rst_n), .wr_thr(mcsfc_if_i.wr_thr),
    .wr_cmd(mcsfc_if_i.wr_cmd), .rd_rhr(mcsfc_if_i.rd_rhr), .wdata(mcsfc_if_i.wdata),
    .rhr(mcsfc_if_i.rhr), .status(mcsfc_if_i.status), .cts_n(mcsfc_if_i.cts_n),
    .tx_bit_clock(mcsfc_if_i.tx_bit_clock), .rx_bit_clock(mcsfc_if_i.rx_bit_clock),
    .tx_idle_flag(mcsfc_if_i.tx_idle_flag), .tx_hold_free_flag(mcsfc_if_i.tx_hold_free_flag),
    .rx_hold_full_flag(mcsfc_if_i.rx_hold_full_flag), .first_char_flag(mcsfc_if_i.first_char_flag));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // in loop-back the line must never leave its high level
  always @(posedge clk) begin
    if (!rst_n) txd_low <= 1'b0;
    else if (cut && txd !== 1'b1) txd_low <= 1'b1;
  end

  task summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  // one avalon cycle; held until waitrequest is seen low
  task av(input logic w, input logic [4:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wd <= 32'(d);
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 40);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (k >= 40) begin
      n_mismatch++;
      summarize;
    end
  endtask
  // status polling is bounded, a stuck flag ends the run
  task wait_st(input int b, input logic v);
    int k;
    k = 0;
    do begin
      av(1'b0, `MCSFC_A_STATUS, 8'h00);
      k++;
    end while (q[b] !== v && k < 400);
    if (k >= 400) begin
      n_mismatch++;
      summarize;
    end
  endtask

  initial begin
    int n;
    {rd, wr, cut, addr, wd, n_mismatch, total_checks} = '0;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    av(1'b0, `MCSFC_A_STATUS, 8'h00);
    chk(q, 32'h0000_0005, "reset status");
    av(1'b0, 5'h18, 8'h00);
    chk(q, 32'h0000_0000, "unmapped read");
    foreach (rows[r]) begin
      av(1'b1, `MCSFC_A_MODE, rows[r][47:40]);
      n = rows[r][39:32];
      for (int i = 0; i <= n; i++) begin
        if (i < n) begin
          wait_st(`MCSFC_ST_FREE, 1'b1);
          av(1'b1, `MCSFC_A_TXDATA, rows[r][8*i +: 8]);
        end
        if (i > 0) begin
          wait_st(`MCSFC_ST_FULL, 1'b1);
          chk(q[7:3], {1'b0, i == 1, 3'b000}, "first flag or error");
          av(1'b0, `MCSFC_A_RXDATA, 8'h00);
          chk(q, 32'(rows[r][8*(i-1) +: 8]), "rx data");
        end
      end
      wait_st(`MCSFC_ST_IDLE, 1'b1);
      chk(q, (n == 1) ? 32'h0000_0045 : 32'h0000_0005, "end of word");
    end
    // clear-to-send high holds the transmitter
    av(1'b1, `MCSFC_A_HCTRL, 8'h01);
    av(1'b0, `MCSFC_A_HCTRL, 8'h00);
    chk(q, 32'h0000_0001, "clear-to-send held");
    av(1'b1, `MCSFC_A_MODE, 8'h00);
    av(1'b1, `MCSFC_A_TXDATA, 8'h0A);
    repeat (40) @(posedge clk);
    av(1'b0, `MCSFC_A_STATUS, 8'h00);
    chk(q[0], 1'b0, "start while blocked");
    av(1'b1, `MCSFC_A_HCTRL, 8'h00);
    wait_st(`MCSFC_ST_FULL, 1'b1);
    av(1'b0, `MCSFC_A_RXDATA, 8'h00);
    chk(q, 32'h0000_000A, "data after release");
    // second char of a word never loaded
    av(1'b1, `MCSFC_A_MODE, 8'h1C);
    av(1'b1, `MCSFC_A_TXDATA, 8'h81);
    wait_st(`MCSFC_ST_WORD, 1'b1);
    chk(q[4], 1'b1, "underrun");
    av(1'b1, `MCSFC_A_CMD, 8'h35);
    av(1'b0, `MCSFC_A_STATUS, 8'h00);
    chk(q[5:3], 3'b000, "errors cleared");
    // drain the padded character so the next case starts with an empty holding register
    av(1'b0, `MCSFC_A_RXDATA, 8'h00);
    chk(q, 32'h0000_00FF, "padded char");
    // unread character gets overwritten
    av(1'b1, `MCSFC_A_TXDATA, 8'h11);
    wait_st(`MCSFC_ST_FREE, 1'b1);
    av(1'b1, `MCSFC_A_TXDATA, 8'h22);
    wait_st(`MCSFC_ST_OVR, 1'b1);
    av(1'b0, `MCSFC_A_RXDATA, 8'h00);
    chk(q, 32'h0000_0022, "newest char kept");
    av(1'b1, `MCSFC_A_CMD, 8'h35);
    // loop-back with the outside line stuck low
    av(1'b1, `MCSFC_A_CMD, 8'h45);
    cut <= 1'b1;
    av(1'b1, `MCSFC_A_MODE, 8'h0C);
    av(1'b1, `MCSFC_A_TXDATA, 8'h96);
    wait_st(`MCSFC_ST_FULL, 1'b1);
    chk(q[3], 1'b0, "loop flags");
    av(1'b0, `MCSFC_A_RXDATA, 8'h00);
    chk(q, 32'h0000_0096, "loop data");
    chk(txd_low, 1'b0, "line left high");
    cut <= 1'b0;
    // forced spacing on an idle transmitter, receiver off
    av(1'b1, `MCSFC_A_CMD, 8'h09);
    // one full bit clock period plus the sync and output flops
    repeat (12) @(posedge clk);
    chk(txd, 1'b0, "break level");
    // reset in mid-run, with spacing still forced
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(txd, 1'b1, "line during reset");
    rst_n <= 1'b1;
    av(1'b0, `MCSFC_A_STATUS, 8'h00);
    chk(q, 32'h0000_0005, "status after reset");
    av(1'b0, `MCSFC_A_RXDATA, 8'h00);
    chk(q, 32'h0000_0000, "holding after reset");
    summarize;
  end
endmodule // multichar_serial_flow_control_tb

// [core/mcsfc_consts.svh]
`ifndef MCSFC_CONSTS_SVH
`define MCSFC_CONSTS_SVH

// command register fields
`define MCSFC_CMD_TX_ON     0
`define MCSFC_CMD_RX_ON     2
`define MCSFC_CMD_SPACE     3
`define MCSFC_CMD_ERR_CLR   4
`define MCSFC_CMD_LOOP      6
`define MCSFC_CMD_RESET     8'h25
// mode register fields
`define MCSFC_MODE_LEN_LO   2
`define MCSFC_MODE_LEN_HI   3
`define MCSFC_MODE_CHR_LO   4
`define MCSFC_MODE_CHR_HI   6
`define MCSFC_MODE_STOP2    7
`define MCSFC_MODE_RESET    8'h3C
`define MCSFC_LEN_BASE      3'h4
// status bits
`define MCSFC_ST_FREE       0
`define MCSFC_ST_FULL       1
`define MCSFC_ST_IDLE       2
`define MCSFC_ST_OVR        3
`define MCSFC_ST_UND        4
`define MCSFC_ST_WORD       5
`define MCSFC_ST_FIRST      6
// host avalon byte addresses
`define MCSFC_A_CMD         5'h00
`define MCSFC_A_MODE        5'h04
`define MCSFC_A_TXDATA      5'h08
`define MCSFC_A_RXDATA      5'h0C
`define MCSFC_A_STATUS      5'h10
`define MCSFC_A_HCTRL       5'h14
`define MCSFC_HCTRL_CTS_N   0
`define MCSFC_DIV_DEFAULT   8

`endif

// [core/mcsfc_device.sv]
`timescale 1ns/1ps
`include "mcsfc_consts.svh"
module mcsfc_device (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // processor side
  mcsfc_if.dev      bus,
  // serial line
  input  wire logic rxd_i,
  output logic      txd_o
);
  logic [7:0] cmd_reg;
  logic [7:0] mode_reg;
  logic [2:0] txc_sync_reg;
  logic [2:0] rxc_sync_reg;
  logic [1:0] rxd_sync_reg;
  logic       txd_reg;

  // bit clocks and line come from outside: two flops before use
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txc_sync_reg <= 3'h0;
      rxc_sync_reg <= 3'h0;
      rxd_sync_reg <= 2'h3;
    end else begin
      txc_sync_reg <= {txc_sync_reg[1:0], bus.tx_bit_clock};
      rxc_sync_reg <= {rxc_sync_reg[1:0], bus.rx_bit_clock};
      rxd_sync_reg <= {rxd_sync_reg[0], rxd_i};
    end
  end

  wire       tx_tick    = txc_sync_reg[1] & ~txc_sync_reg[2];
  wire       rx_tick    = rxc_sync_reg[1] & ~rxc_sync_reg[2];
  wire       tx_on      = cmd_reg[`MCSFC_CMD_TX_ON];
  wire       rx_on      = cmd_reg[`MCSFC_CMD_RX_ON];
  wire       force_sp   = cmd_reg[`MCSFC_CMD_SPACE];
  wire       loop_on    = cmd_reg[`MCSFC_CMD_LOOP];
  wire       err_clr    = bus.wr_cmd & bus.wdata[`MCSFC_CMD_ERR_CLR];
  wire [2:0] last_bit   = {1'b0, mode_reg[`MCSFC_MODE_LEN_HI:`MCSFC_MODE_LEN_LO]} + `MCSFC_LEN_BASE;
  wire [2:0] last_char  = mode_reg[`MCSFC_MODE_CHR_HI:`MCSFC_MODE_CHR_LO];
  wire       two_stop   = mode_reg[`MCSFC_MODE_STOP2];

  // command and mode registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_reg  <= `MCSFC_CMD_RESET;
      mode_reg <= `MCSFC_MODE_RESET;
    end else begin
      if (bus.wr_cmd) cmd_reg <= bus.wdata;
      if (bus.wr_mode) mode_reg <= bus.wdata;
    end
  end

  // transmitter
  mcsfc_pkg::mcsfc_tx_state_e tx_state_reg, tx_state_next;
  logic [7:0] thr_reg;
  logic       thr_full_reg, thr_full_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [2:0] tx_char_reg, tx_char_next;
  logic       tx_line_reg, tx_line_next;
  logic       abort_reg, abort_next;
  logic       stop_cnt_reg, stop_cnt_next;
  logic       underrun_reg;
  logic       thr_take;
  logic       underrun_set;

  wire tx_start  = tx_on & ~bus.cts_n & ~force_sp & thr_full_reg;
  // spacing breaks into a word only in loop-back; otherwise it waits for idle
  wire tx_serial = (loop_on & force_sp) ? 1'b0 : tx_line_reg;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_shift_next = tx_shift_reg;
    tx_bit_next   = tx_bit_reg;
    tx_char_next  = tx_char_reg;
    tx_line_next  = tx_line_reg;
    abort_next    = abort_reg;
    stop_cnt_next = stop_cnt_reg;
    thr_take      = 1'b0;
    underrun_set  = 1'b0;
    if (tx_tick) begin
      case (tx_state_reg)
        mcsfc_pkg::MCSFC_TX_IDLE: begin
          tx_line_next = ~force_sp;
          if (tx_start) begin
            tx_line_next  = 1'b0;
            tx_shift_next = thr_reg;
            thr_take      = 1'b1;
            tx_bit_next   = 3'h0;
            tx_char_next  = 3'h0;
            abort_next    = 1'b0;
            tx_state_next = mcsfc_pkg::MCSFC_TX_DATA;
          end
        end
        mcsfc_pkg::MCSFC_TX_DATA: begin
          tx_line_next  = tx_shift_reg[0];
          tx_shift_next = {1'b1, tx_shift_reg[7:1]};
          tx_bit_next   = tx_bit_reg + 3'h1;
          if (tx_bit_reg == last_bit) begin
            tx_bit_next  = 3'h0;
            tx_char_next = tx_char_reg + 3'h1;
            if (tx_char_reg == last_char) begin
              stop_cnt_next = 1'b0;
              tx_state_next = mcsfc_pkg::MCSFC_TX_STOP;
            end else if (thr_full_reg & ~abort_reg) begin
              tx_shift_next = thr_reg;
              thr_take      = 1'b1;
            end else begin
              // pad the word with marks, then a bad stop bit marks it
              tx_shift_next = 8'hFF;
              underrun_set  = ~abort_reg;
              abort_next    = 1'b1;
            end
          end
        end
        default: begin
          tx_line_next  = stop_cnt_reg | ~abort_reg;
          stop_cnt_next = 1'b1;
          if (stop_cnt_reg == two_stop) tx_state_next = mcsfc_pkg::MCSFC_TX_IDLE;
        end
      endcase
    end
  end

  // a write arriving with the load keeps the holding register full
  assign thr_full_next = bus.wr_thr | (thr_full_reg & ~thr_take);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_state_reg <= mcsfc_pkg::MCSFC_TX_IDLE;
      thr_reg      <= 8'h00;
      thr_full_reg <= 1'b0;
      tx_shift_reg <= 8'hFF;
      tx_bit_reg   <= 3'h0;
      tx_char_reg  <= 3'h0;
      tx_line_reg  <= 1'b1;
      abort_reg    <= 1'b0;
      stop_cnt_reg <= 1'b0;
      underrun_reg <= 1'b0;
      txd_reg      <= 1'b1;
    end else begin
      tx_state_reg <= tx_state_next;
      if (bus.wr_thr) thr_reg <= bus.wdata;
      thr_full_reg <= thr_full_next;
      tx_shift_reg <= tx_shift_next;
      tx_bit_reg   <= tx_bit_next;
      tx_char_reg  <= tx_char_next;
      tx_line_reg  <= tx_line_next;
      abort_reg    <= abort_next;
      stop_cnt_reg <= stop_cnt_next;
      underrun_reg <= underrun_set | (underrun_reg & ~err_clr);
      txd_reg      <= loop_on | tx_line_reg;
    end
  end

  // receiver
  mcsfc_pkg::mcsfc_rx_state_e rx_state_reg, rx_state_next;
  logic [7:0] asm_reg, asm_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [2:0] rx_char_reg, rx_char_next;
  logic [7:0] rhr_reg, rhr_next;
  logic       full_reg;
  logic       first_reg, first_next;
  logic       overrun_reg;
  logic       word_err_reg;
  logic       deliver;
  logic       word_err_set;

  // loop-back feeds the transmitter straight in and ignores the pin
  wire rx_in = loop_on ? tx_serial : rxd_sync_reg[1];

  always_comb begin
    rx_state_next = rx_state_reg;
    asm_next      = asm_reg;
    rx_bit_next   = rx_bit_reg;
    rx_char_next  = rx_char_reg;
    rhr_next      = rhr_reg;
    first_next    = first_reg;
    deliver       = 1'b0;
    word_err_set  = 1'b0;
    if (!rx_on) begin
      rx_state_next = mcsfc_pkg::MCSFC_RX_IDLE;
      first_next    = 1'b0;
    end else if (rx_tick) begin
      case (rx_state_reg)
        mcsfc_pkg::MCSFC_RX_IDLE: begin
          if (!rx_in) begin
            asm_next      = 8'h00;
            rx_bit_next   = 3'h0;
            rx_char_next  = 3'h0;
            rx_state_next = mcsfc_pkg::MCSFC_RX_DATA;
          end
        end
        mcsfc_pkg::MCSFC_RX_DATA: begin
          asm_next[rx_bit_reg] = rx_in;
          rx_bit_next = rx_bit_reg + 3'h1;
          if (rx_bit_reg == last_bit) begin
            rhr_next     = asm_next;
            deliver      = 1'b1;
            first_next   = (rx_char_reg == 3'h0);
            asm_next     = 8'h00;
            rx_bit_next  = 3'h0;
            rx_char_next = rx_char_reg + 3'h1;
            if (rx_char_reg == last_char) rx_state_next = mcsfc_pkg::MCSFC_RX_STOP;
          end
        end
        default: begin
          word_err_set  = ~rx_in;
          rx_state_next = mcsfc_pkg::MCSFC_RX_IDLE;
        end
      endcase
    end
  end

  // a read in the delivery cycle takes the old character, so no overrun
  wire overrun_set = deliver & full_reg & ~bus.rd_rhr;
  wire full_next   = rx_on & (deliver | (full_reg & ~bus.rd_rhr));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_state_reg <= mcsfc_pkg::MCSFC_RX_IDLE;
      asm_reg      <= 8'h00;
      rx_bit_reg   <= 3'h0;
      rx_char_reg  <= 3'h0;
      rhr_reg      <= 8'h00;
      full_reg     <= 1'b0;
      first_reg    <= 1'b0;
      overrun_reg  <= 1'b0;
      word_err_reg <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      asm_reg      <= asm_next;
      rx_bit_reg   <= rx_bit_next;
      rx_char_reg  <= rx_char_next;
      rhr_reg      <= rhr_next;
      full_reg     <= full_next;
      first_reg    <= first_next;
      overrun_reg  <= overrun_set | (overrun_reg & ~err_clr);
      word_err_reg <= word_err_set | (word_err_reg & ~err_clr);
    end
  end

  // flags come from the same logic in every mode
  wire tx_free = tx_on & ~thr_full_reg;
  wire tx_idle = tx_free & (tx_state_reg == mcsfc_pkg::MCSFC_TX_IDLE);

  assign bus.tx_hold_free_flag = tx_free;
  assign bus.tx_idle_flag      = tx_idle;
  assign bus.rx_hold_full_flag = full_reg;
  assign bus.first_char_flag   = first_reg;
  assign bus.rhr               = rhr_reg;
  assign bus.status            = {1'b0, first_reg, word_err_reg, underrun_reg,
                                  overrun_reg, tx_idle, full_reg, tx_free};
  assign txd_o                 = txd_reg;
endmodule // mcsfc_device

// [core/mcsfc_host.sv]
`timescale 1ns/1ps
`include "mcsfc_consts.svh"
module mcsfc_host #(
  parameter int DIV = `MCSFC_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // device side
  mcsfc_if.host            bus
);
  mcsfc_pkg::mcsfc_host_state_e state_reg;
  logic [31:0] rdata_reg;
  logic        cts_n_reg;
  logic        bclk_reg;
  logic [15:0] div_reg;

  wire idle    = (state_reg == mcsfc_pkg::MCSFC_H_IDLE);
  wire req     = idle & (avs_read_i | avs_write_i);
  wire a_cmd   = (avs_address_i == `MCSFC_A_CMD);
  wire a_mode  = (avs_address_i == `MCSFC_A_MODE);
  wire a_tx    = (avs_address_i == `MCSFC_A_TXDATA);
  wire a_rx    = (avs_address_i == `MCSFC_A_RXDATA);
  wire a_stat  = (avs_address_i == `MCSFC_A_STATUS);
  wire a_hctrl = (avs_address_i == `MCSFC_A_HCTRL);
  wire wr      = idle & avs_write_i;
  wire rd      = idle & avs_read_i;

  // unmapped reads return zero, unmapped writes are dropped
  logic [31:0] rsel;
  assign rsel = a_rx    ? {24'h00_0000, bus.rhr} :
                a_stat  ? {24'h00_0000, bus.status} :
                a_hctrl ? {31'h0000_0000, cts_n_reg} : 32'h0000_0000;

  assign bus.wr_cmd       = wr & a_cmd;
  assign bus.wr_mode      = wr & a_mode;
  assign bus.wr_thr       = wr & a_tx;
  assign bus.rd_rhr       = rd & a_rx;
  assign bus.wdata        = avs_writedata_i[7:0];
  assign bus.cts_n        = cts_n_reg;
  assign bus.tx_bit_clock = bclk_reg;
  assign bus.rx_bit_clock = bclk_reg;
  assign avs_waitrequest_o = idle;
  assign avs_readdata_o    = rdata_reg;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= mcsfc_pkg::MCSFC_H_IDLE;
      rdata_reg <= 32'h0000_0000;
      cts_n_reg <= 1'b0;
    end else begin
      state_reg <= req ? mcsfc_pkg::MCSFC_H_ACK : mcsfc_pkg::MCSFC_H_IDLE;
      if (rd) rdata_reg <= rsel;
      if (wr & a_hctrl) cts_n_reg <= avs_writedata_i[`MCSFC_HCTRL_CTS_N];
    end
  end

  // one divided clock drives both bit clocks so they always match
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg  <= 16'h0000;
      bclk_reg <= 1'b0;
    end else if (div_reg == 16'(DIV - 1)) begin
      div_reg  <= 16'h0000;
      bclk_reg <= ~bclk_reg;
    end else begin
      div_reg  <= div_reg + 16'h0001;
    end
  end
endmodule // mcsfc_host

// [core/mcsfc_if.sv]
`timescale 1ns/1ps
interface mcsfc_if;
  logic       wr_thr;
  logic       wr_cmd;
  logic       wr_mode;
  logic       rd_rhr;
  logic [7:0] wdata;
  logic [7:0] rhr;
  logic [7:0] status;
  logic       cts_n;
  logic       tx_bit_clock;
  logic       rx_bit_clock;
  logic       tx_idle_flag;
  logic       tx_hold_free_flag;
  logic       rx_hold_full_flag;
  logic       first_char_flag;

  modport dev (
    input  wr_thr, wr_cmd, wr_mode, rd_rhr, wdata, cts_n, tx_bit_clock, rx_bit_clock,
    output rhr, status, tx_idle_flag, tx_hold_free_flag, rx_hold_full_flag, first_char_flag
  );
  modport host (
    output wr_thr, wr_cmd, wr_mode, rd_rhr, wdata, cts_n, tx_bit_clock, rx_bit_clock,
    input  rhr, status, tx_idle_flag, tx_hold_free_flag, rx_hold_full_flag, first_char_flag
  );
endinterface

// [core/mcsfc_pkg.sv]
package mcsfc_pkg;
  typedef enum logic [1:0] {MCSFC_TX_IDLE, MCSFC_TX_DATA, MCSFC_TX_STOP} mcsfc_tx_state_e;
  typedef enum logic [1:0] {MCSFC_RX_IDLE, MCSFC_RX_DATA, MCSFC_RX_STOP} mcsfc_rx_state_e;
  typedef enum logic {MCSFC_H_IDLE, MCSFC_H_ACK} mcsfc_host_state_e;
endpackage
